//--- core/tcc_timer.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
// Function
// - Buffer write sets flag; update copies, clears
// - Capture into buffer sets buffer flag
// - Capture buffer and channel form two-entry queue
// - Software reaches working and buffer registers
// - Count by direction; up wraps to zero
// - Down count reloads period at zero
// - Counter write wins immediately; direction changeable
// - Event directed up/down and quadrature counting
// - Period write immediate; buffer waits update
// - Channel A event source, next channels follow
// - Enabled channels copy counter on capture
// - Short period stores edge polarity in MSB
// - Input capture captures every event, sets flag
// - Frequency capture captures then restarts counter
// - Pulse width: rise restarts, fall captures
// - Optional one-cycle delay of capture events
// - Full queue drops capture, sets error
// - Zero is 16'h0000; top is period or channel A
// - Update at zero or top by mode and direction
// - Reset leaves counter stopped, no clock
module tcc_timer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] ev_strobe,
   input wire logic [7:0] ev_pin_edge,
   input wire logic [7:0] ev_rising,
   output logic ovf_event
);
   tcc_pkg::tcc_state_s s_reg;
   tcc_pkg::tcc_state_s s_next;
   logic [7:0] ev_cur;
   logic [7:0] edge_cur;
   logic [7:0] rise_cur;
   logic wr;
   logic wr_cnt;
   logic psc_tick;
   logic clk_tick;
   logic capt;
   logic dir_eff;
   logic at_top;
   logic at_zero;
   logic wrap;
   logic upd;
   logic rst;
   logic [15:0] top;
   logic [15:0] ch_work [`TCC_NCH];
   logic [15:0] ch_buf [`TCC_NCH];
   logic [15:0] cap_val [`TCC_NCH];
   logic [3:0] ch_buf_valid;
   logic [3:0] ch_if;
   logic [3:0] ch_err;
   logic [3:0] cap_stb;
   logic [3:0] match;
   logic [3:0] wr_work;
   logic [3:0] wr_buf;
   logic [3:0] rd_work;
   logic [3:0] clr_if;
   logic [31:0] rd_val;

   // ------------------------------
   // Helpers
   // ------------------------------
   function automatic logic [2:0] ev_idx(input logic [2:0] src,
                                         input logic [1:0] ch);
      ev_idx = src + {1'b0, ch};
   endfunction

   function automatic logic [7:0] reg_at(input logic [7:0] base,
                                         input logic [1:0] i);
      reg_at = base + {4'h0, i, 2'b00};
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= `TCC_A_LAST);
   endfunction

   // ------------------------------
   // Bus slave
   // ------------------------------
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);
   assign prdata = s_reg.rdata;
   assign wr = psel & penable & pwrite;
   assign wr_cnt = wr & (paddr == `TCC_A_CNT);
   assign ovf_event = s_reg.ovf_ev;

   // ------------------------------
   // Clock and count control
   // ------------------------------
   tcc_prescaler u_psc (
      .clk(clk),
      .nrst(nrst),
      .sel(s_reg.clock_source_select[2:0]),
      .tick(psc_tick)
   );

   assign ev_cur = s_reg.evdly ? s_reg.ev_d : ev_strobe;
   assign edge_cur = s_reg.evdly ? s_reg.edge_d : ev_pin_edge;
   assign rise_cur = s_reg.evdly ? s_reg.rise_d : ev_rising;
   assign capt = (s_reg.event_action_select == tcc_pkg::TCC_EVA_CAPT)
      || (s_reg.event_action_select == tcc_pkg::TCC_EVA_FRQ)
      || (s_reg.event_action_select == tcc_pkg::TCC_EVA_PW);

   always_comb
   begin
      if (s_reg.clock_source_select == 4'h0)
         clk_tick = 1'b0;
      else if (s_reg.clock_source_select[3])
         clk_tick = ev_strobe[s_reg.clock_source_select[2:0]];
      else
         clk_tick = psc_tick;
      case (s_reg.event_action_select)
         tcc_pkg::TCC_EVA_UPDN:
            dir_eff = ev_cur[s_reg.evsrc];
         tcc_pkg::TCC_EVA_QDEC:
            dir_eff = ev_cur[ev_idx(s_reg.evsrc, 2'h1)];
         default:
            dir_eff = s_reg.dir;
      endcase
   end

   assign top = (s_reg.wgm == tcc_pkg::TCC_WG_FRQ) ? ch_work[0] : s_reg.per;
   assign at_top = s_reg.cnt == top;
   assign at_zero = s_reg.cnt == 16'h0000;
   assign wrap = clk_tick & (dir_eff ? at_zero : at_top);
   assign upd = clk_tick & ((s_reg.wgm == tcc_pkg::TCC_WG_DS) ? at_zero
      : (dir_eff ? at_zero : at_top));

   // ------------------------------
   // Channel steering
   // ------------------------------
   always_comb
   begin
      logic [2:0] e;
      e = '0;
      rst = 1'b0;
      if (s_reg.event_action_select == tcc_pkg::TCC_EVA_RESTART)
         rst = ev_cur[s_reg.evsrc];
      if (s_reg.event_action_select == tcc_pkg::TCC_EVA_QDEC)
         rst = ev_cur[ev_idx(s_reg.evsrc, 2'h2)];
      for (int i = 0; i < `TCC_NCH; i++)
      begin
         e = ev_idx(s_reg.evsrc, 2'(i));
         cap_stb[i] = 1'b0;
         if (ev_cur[e] & s_reg.ccen[i])
         begin
            case (s_reg.event_action_select)
               tcc_pkg::TCC_EVA_CAPT:
                  cap_stb[i] = 1'b1;
               tcc_pkg::TCC_EVA_FRQ:
               begin
                  cap_stb[i] = 1'b1;
                  rst = 1'b1;
               end
               tcc_pkg::TCC_EVA_PW:
               begin
                  cap_stb[i] = ~rise_cur[e];
                  rst = rst | rise_cur[e];
               end
               default:
                  cap_stb[i] = 1'b0;
            endcase
         end
         cap_val[i] = s_reg.cnt;
         if ((s_reg.per < `TCC_POL_LIMIT) && edge_cur[e])
            cap_val[i][`TCC_F_POL] = rise_cur[e];
         match[i] = clk_tick & ~capt & (s_reg.cnt == ch_work[i]);
         wr_work[i] = wr & (paddr == reg_at(`TCC_A_CC0, 2'(i)));
         wr_buf[i] = wr & (paddr == reg_at(`TCC_A_CCBUF0, 2'(i)));
         rd_work[i] = psel & penable & ~pwrite
            & (paddr == reg_at(`TCC_A_CC0, 2'(i)));
         clr_if[i] = wr & (paddr == `TCC_A_FLAGS)
            & pwdata[`TCC_F_CCIF][i];
      end
   end

   for (genvar g = 0; g < `TCC_NCH; g++)
   begin : g_ch
      tcc_channel u_ch (
         .clk(clk),
         .nrst(nrst),
         .capt(capt),
         .cap_stb(cap_stb[g]),
         .cap_val(cap_val[g]),
         .upd(upd),
         .match(match[g]),
         .wr_work(wr_work[g]),
         .wr_buf(wr_buf[g]),
         .wdata(pwdata[15:0]),
         .rd_work(rd_work[g]),
         .clr_if(clr_if[g]),
         .work(ch_work[g]),
         .bufv(ch_buf[g]),
         .buffer_valid_flag(ch_buf_valid[g]),
         .ifl(ch_if[g]),
         .err(ch_err[g])
      );
   end

   // ------------------------------
   // Read data
   // ------------------------------
   always_comb
   begin
      rd_val = '0;
      case (paddr)
         `TCC_A_CTRLA: rd_val[`TCC_F_CLK_SRC] = s_reg.clock_source_select;
         `TCC_A_CTRLB:
         begin
            rd_val[`TCC_F_CCEN] = s_reg.ccen;
            rd_val[`TCC_F_WGM] = s_reg.wgm;
         end
         `TCC_A_CTRLD:
         begin
            rd_val[`TCC_F_ACTION] = s_reg.event_action_select;
            rd_val[`TCC_F_EVDLY] = s_reg.evdly;
            rd_val[`TCC_F_EVSRC] = s_reg.evsrc;
         end
         `TCC_A_CTRLE: rd_val[`TCC_F_DIR] = s_reg.dir;
         `TCC_A_FLAGS:
         begin
            rd_val[`TCC_F_OVF] = s_reg.ovf;
            rd_val[`TCC_F_ERR] = s_reg.err;
            rd_val[`TCC_F_CCIF] = ch_if;
         end
         `TCC_A_BVSTAT:
         begin
            rd_val[`TCC_F_PERBV] = s_reg.per_buffer_valid_flag;
            rd_val[`TCC_F_CCBV] = ch_buf_valid;
         end
         `TCC_A_CNT: rd_val[15:0] = s_reg.cnt;
         `TCC_A_PER: rd_val[15:0] = s_reg.per;
         `TCC_A_PER_BUF: rd_val[15:0] = s_reg.period_buffer_register;
         default:
         begin
            for (int i = 0; i < `TCC_NCH; i++)
            begin
               if (paddr == reg_at(`TCC_A_CC0, 2'(i)))
                  rd_val[15:0] = ch_work[i];
               if (paddr == reg_at(`TCC_A_CCBUF0, 2'(i)))
                  rd_val[15:0] = ch_buf[i];
            end
         end
      endcase
   end

   // ------------------------------
   // State update
   // ------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.ev_d = ev_strobe;
      s_next.edge_d = ev_pin_edge;
      s_next.rise_d = ev_rising;
      s_next.ovf_ev = wrap;
      if (psel & ~penable)
         s_next.rdata = rd_val;
      if (wr_cnt)
         s_next.cnt = pwdata[15:0];
      else if (rst)
         s_next.cnt = '0;
      else if (clk_tick & dir_eff)
         s_next.cnt = at_zero ? s_reg.per : s_reg.cnt - 16'h0001;
      else if (clk_tick)
         s_next.cnt = at_top ? 16'h0000 : s_reg.cnt + 16'h0001;
      if (upd & s_reg.per_buffer_valid_flag)
      begin
         s_next.per = s_reg.period_buffer_register;
         s_next.per_buffer_valid_flag = 1'b0;
      end
      if (wr & (paddr == `TCC_A_FLAGS))
      begin
         if (pwdata[`TCC_F_OVF])
            s_next.ovf = 1'b0;
         if (pwdata[`TCC_F_ERR])
            s_next.err = 1'b0;
      end
      if (wrap)
         s_next.ovf = 1'b1;
      if (|ch_err)
         s_next.err = 1'b1;
      if (wr)
      begin
         case (paddr)
            `TCC_A_CTRLA: s_next.clock_source_select = pwdata[`TCC_F_CLK_SRC];
            `TCC_A_CTRLB:
            begin
               s_next.ccen = pwdata[`TCC_F_CCEN];
               s_next.wgm = tcc_pkg::tcc_wgm_e'(pwdata[`TCC_F_WGM]);
            end
            `TCC_A_CTRLD:
            begin
               s_next.event_action_select =
                  tcc_pkg::tcc_action_e'(pwdata[`TCC_F_ACTION]);
               s_next.evdly = pwdata[`TCC_F_EVDLY];
               s_next.evsrc = pwdata[`TCC_F_EVSRC];
            end
            `TCC_A_CTRLE: s_next.dir = pwdata[`TCC_F_DIR];
            `TCC_A_PER: s_next.per = pwdata[15:0];
            `TCC_A_PER_BUF:
            begin
               s_next.period_buffer_register = pwdata[15:0];
               s_next.per_buffer_valid_flag = 1'b1;
            end
            default: s_next.per = s_next.per;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '0;
         s_reg.per <= `TCC_PER_RST;
      end
      else
         s_reg <= s_next;
   end

   // ------------------------------
   // Checks
   // ------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_OFF_STOP: assert property (s_reg.clock_source_select == 4'h0
      && !wr_cnt && !rst |=> $stable(s_reg.cnt))
      else $error("counter moved without clock");
   AST_UP_WRAP: assert property (clk_tick && !dir_eff && at_top
      && !wr_cnt && !rst |=> s_reg.cnt == 16'h0000)
      else $error("no wrap to zero");
   AST_DN_RELOAD: assert property (clk_tick && dir_eff && at_zero
      && !wr_cnt && !rst |=> s_reg.cnt == $past(s_reg.per))
      else $error("no reload at zero");
   AST_SW_CNT: assert property (wr_cnt
      |=> s_reg.cnt == $past(pwdata[15:0]))
      else $error("counter write lost");
   AST_PER_HOLD: assert property (!upd && !(wr && paddr == `TCC_A_PER)
      |=> $stable(s_reg.per))
      else $error("period changed off update");
   AST_PW_RESTART: assert property (ev_cur[s_reg.evsrc]
      && s_reg.event_action_select == tcc_pkg::TCC_EVA_PW
      && s_reg.ccen[0] && rise_cur[s_reg.evsrc]
      && !wr_cnt |=> s_reg.cnt == 16'h0000)
      else $error("no restart on rising edge");

   COV_CAPT: cover property (capt && |cap_stb ##1 |ch_buf_valid);
   COV_ERR: cover property (|ch_err);
   COV_PER_UPD: cover property (upd && s_reg.per_buffer_valid_flag);
endmodule // tcc_timer

//--- core/tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_A_CTRLA 8'h00
`define TCC_A_CTRLB 8'h04
`define TCC_A_CTRLD 8'h08
`define TCC_A_CTRLE 8'h0c
`define TCC_A_FLAGS 8'h10
`define TCC_A_BVSTAT 8'h14
`define TCC_A_CNT 8'h18
`define TCC_A_PER 8'h1c
`define TCC_A_PER_BUF 8'h20
`define TCC_A_CC0 8'h24
`define TCC_A_CCBUF0 8'h34
`define TCC_A_LAST 8'h40
`define TCC_F_CLK_SRC 3:0
`define TCC_F_CCEN 7:4
`define TCC_F_WGM 1:0
`define TCC_F_ACTION 7:5
`define TCC_F_EVDLY 4
`define TCC_F_EVSRC 2:0
`define TCC_F_DIR 0
`define TCC_F_OVF 0
`define TCC_F_ERR 1
`define TCC_F_CCIF 7:4
`define TCC_F_PERBV 0
`define TCC_F_CCBV 4:1
`define TCC_F_POL 15
`define TCC_F_LOW 14:0
`define TCC_NCH 4
`define TCC_PER_RST 16'hffff
`define TCC_POL_LIMIT 16'h8000
`define TCC_DIV2_MASK 10'h001
`define TCC_DIV4_MASK 10'h003
`define TCC_DIV8_MASK 10'h007
`define TCC_DIV64_MASK 10'h03f
`define TCC_DIV256_MASK 10'h0ff
`define TCC_DIV1024_MASK 10'h3ff
`endif

//--- core/tcc_pkg.sv
package tcc_pkg;
   typedef enum logic [2:0] {
      TCC_EVA_OFF,
      TCC_EVA_CAPT,
      TCC_EVA_UPDN,
      TCC_EVA_QDEC,
      TCC_EVA_RESTART,
      TCC_EVA_FRQ,
      TCC_EVA_PW
   } tcc_action_e;
   typedef enum logic [1:0] {TCC_WG_NORMAL, TCC_WG_FRQ, TCC_WG_DS} tcc_wgm_e;
   typedef struct packed {
      logic [15:0] work;
      logic [15:0] bufv;
      logic buffer_valid_flag;
      logic ifl;
   } tcc_chan_s;
   typedef struct packed {
      logic [9:0] cnt;
   } tcc_psc_s;
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] per;
      logic [15:0] period_buffer_register;
      logic per_buffer_valid_flag;
      logic dir;
      logic [3:0] clock_source_select;
      logic [3:0] ccen;
      tcc_wgm_e wgm;
      tcc_action_e event_action_select;
      logic evdly;
      logic [2:0] evsrc;
      logic ovf;
      logic err;
      logic ovf_ev;
      logic [7:0] ev_d;
      logic [7:0] edge_d;
      logic [7:0] rise_d;
      logic [31:0] rdata;
   } tcc_state_s;
endpackage

//--- core/tcc_prescaler.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_prescaler (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [2:0] sel,
   output logic tick
);
   tcc_pkg::tcc_psc_s s_reg;
   tcc_pkg::tcc_psc_s s_next;
   logic [9:0] mask;

   function automatic logic [9:0] psc_mask(input logic [2:0] s);
      case (s)
         3'h2: psc_mask = `TCC_DIV2_MASK;
         3'h3: psc_mask = `TCC_DIV4_MASK;
         3'h4: psc_mask = `TCC_DIV8_MASK;
         3'h5: psc_mask = `TCC_DIV64_MASK;
         3'h6: psc_mask = `TCC_DIV256_MASK;
         3'h7: psc_mask = `TCC_DIV1024_MASK;
         default: psc_mask = '0;
      endcase
   endfunction

   assign mask = psc_mask(sel);
   assign tick = (s_reg.cnt & mask) == mask;

   always_comb
   begin
      s_next = s_reg;
      s_next.cnt = s_reg.cnt + 10'h001;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule // tcc_prescaler

//--- core/tcc_channel.sv
`timescale 1ns/1ps
module tcc_channel (
   input wire logic clk,
   input wire logic nrst,
   input wire logic capt,
   input wire logic cap_stb,
   input wire logic [15:0] cap_val,
   input wire logic upd,
   input wire logic match,
   input wire logic wr_work,
   input wire logic wr_buf,
   input wire logic [15:0] wdata,
   input wire logic rd_work,
   input wire logic clr_if,
   output logic [15:0] work,
   output logic [15:0] bufv,
   output logic buffer_valid_flag,
   output logic ifl,
   output logic err
);
   tcc_pkg::tcc_chan_s s_reg;
   tcc_pkg::tcc_chan_s s_next;
   logic ovf_hit;

   assign ovf_hit = capt & cap_stb & s_reg.buffer_valid_flag
      & s_reg.ifl;
   assign work = s_reg.work;
   assign bufv = s_reg.bufv;
   assign buffer_valid_flag = s_reg.buffer_valid_flag;
   assign ifl = s_reg.ifl;
   assign err = ovf_hit;

   always_comb
   begin
      s_next = s_reg;
      if (clr_if)
         s_next.ifl = 1'b0;
      if (capt)
      begin
         if (s_reg.buffer_valid_flag & (~s_reg.ifl | rd_work))
         begin
            s_next.work = s_reg.bufv;
            s_next.ifl = 1'b1;
            s_next.buffer_valid_flag = 1'b0;
         end
         else if (rd_work)
            s_next.ifl = 1'b0;
         if (cap_stb & ~ovf_hit)
         begin
            s_next.bufv = cap_val;
            s_next.buffer_valid_flag = 1'b1;
         end
      end
      else
      begin
         if (upd & s_reg.buffer_valid_flag)
         begin
            s_next.work = s_reg.bufv;
            s_next.buffer_valid_flag = 1'b0;
         end
         if (match)
            s_next.ifl = 1'b1;
      end
      if (wr_work)
         s_next.work = wdata;
      if (wr_buf)
      begin
         s_next.bufv = wdata;
         s_next.buffer_valid_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // ------------------------------
   // Checks
   // ------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_CMP_BV: assert property (wr_buf |=> s_reg.buffer_valid_flag)
      else $error("buffer flag not set by write");
   AST_CMP_UPD: assert property (!capt && upd && !wr_work && !wr_buf
      && s_reg.buffer_valid_flag
      |=> !s_reg.buffer_valid_flag && s_reg.work == $past(s_reg.bufv))
      else $error("update copy missing");
   AST_CAP_SET: assert property (capt && cap_stb && !ovf_hit
      && !wr_buf |=> s_reg.buffer_valid_flag
      && s_reg.bufv == $past(cap_val))
      else $error("capture not buffered");
   AST_CAP_QUEUE: assert property (capt && s_reg.buffer_valid_flag
      && !s_reg.ifl && !wr_work |=> s_reg.ifl
      && s_reg.work == $past(s_reg.bufv))
      else $error("queue move missing");
   AST_CAP_OVF: assert property (ovf_hit && !wr_buf && !rd_work
      |-> err ##1 (s_reg.buffer_valid_flag && $stable(s_reg.bufv)))
      else $error("overflow value not discarded");
endmodule // tcc_channel

//--- tb/tcc_event_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Event routing model
// ----------------------------------------
module tcc_event_src (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic [7:0] req_mask,
   input wire logic [7:0] req_pin,
   input wire logic [7:0] req_rise,
   output logic [7:0] ev_strobe,
   output logic [7:0] ev_pin_edge,
   output logic [7:0] ev_rising
);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ev_strobe <= 8'h00;
         ev_pin_edge <= 8'h00;
         ev_rising <= 8'h00;
      end
      else if (req)
      begin
         ev_strobe <= req_mask;
         ev_pin_edge <= req_pin;
         ev_rising <= req_rise;
      end
      else
      begin
         ev_strobe <= 8'h00;
         // Qualifiers toggle outside a strobe
         ev_pin_edge <= ~ev_pin_edge;
         ev_rising <= ~ev_rising;
      end
   end
endmodule // tcc_event_src

//--- tb/tcc_timer_test.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_timer_test;
   logic clk;
   logic nrst;
   logic psel, penable, pwrite, pready, pslverr, ovf_event, req;
   logic [7:0] paddr, req_mask, req_pin, req_rise;
   logic [7:0] ev_strobe, ev_pin_edge, ev_rising;
   logic [31:0] pwdata, prdata, rd_val;
   logic rd_err;
   int num_errors = 0;
   int checked = 0;
   int ovf_cnt = 0;
   int base;

   tcc_timer u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ev_strobe(ev_strobe),
      .ev_pin_edge(ev_pin_edge), .ev_rising(ev_rising),
      .ovf_event(ovf_event));

   tcc_event_src u_evt (.clk(clk), .nrst(nrst), .req(req),
      .req_mask(req_mask), .req_pin(req_pin), .req_rise(req_rise),
      .ev_strobe(ev_strobe), .ev_pin_edge(ev_pin_edge),
      .ev_rising(ev_rising));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (ovf_event === 1'b1)
         ovf_cnt <= ovf_cnt + 1;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask

   task finish_test;
   begin
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
   begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         num_errors++;
         finish_test();
      end
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
   begin
      apb(1'b0, a, 32'h00000000);
      chk(name, rd_val, exp);
   end
   endtask

   task ev(input logic [7:0] m, input logic [7:0] p, input logic [7:0] r);
   begin
      @(posedge clk);
      req <= 1'b1;
      req_mask <= m;
      req_pin <= p;
      req_rise <= r;
      @(posedge clk);
      req <= 1'b0;
      repeat (3) @(posedge clk);
   end
   endtask

   task rst;
   begin
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
   end
   endtask

   task end_test(input string name);
      $display("test %s done", name);
   endtask

   function logic [31:0] ea(input tcc_pkg::tcc_action_e e, input logic dly);
      return {24'h000000, e, dly, 4'h2};
   endfunction

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      req = 1'b0;
      req_mask = 8'h00;
      req_pin = 8'h00;
      req_rise = 8'h00;
      rst();
      rdc("per_rst", `TCC_A_PER, 32'h0000ffff);
      rdc("clock_source_select_rst", `TCC_A_CTRLA, 32'h00000000);
      ev(8'hff, 8'h00, 8'h00);
      rdc("cnt_off", `TCC_A_CNT, 32'h00000000);
      wr(`TCC_A_CTRLA, 32'h0000000f);
      wr(`TCC_A_PER, 32'h00000003);
      rdc("per_now", `TCC_A_PER, 32'h00000003);
      wr(`TCC_A_PER_BUF, 32'h00000002);
      rdc("per_bv", `TCC_A_BVSTAT, 32'h00000001);
      rdc("per_hold", `TCC_A_PER, 32'h00000003);
      base = ovf_cnt;
      repeat (3) ev(8'h80, 8'h00, 8'h00);
      rdc("cnt_top", `TCC_A_CNT, 32'h00000003);
      ev(8'h80, 8'h00, 8'h00);
      rdc("cnt_wrap", `TCC_A_CNT, 32'h00000000);
      chk("ovf", ovf_cnt - base, 32'h00000001);
      rdc("per_upd", `TCC_A_PER, 32'h00000002);
      rdc("bv_clr", `TCC_A_BVSTAT, 32'h00000000);
      wr(`TCC_A_CTRLE, 32'h00000001);
      ev(8'h80, 8'h00, 8'h00);
      rdc("cnt_reload", `TCC_A_CNT, 32'h00000002);
      ev(8'h80, 8'h00, 8'h00);
      rdc("cnt_down", `TCC_A_CNT, 32'h00000001);
      wr(`TCC_A_CNT, 32'h00000007);
      rdc("cnt_wr", `TCC_A_CNT, 32'h00000007);
      rdc("bad_addr", 8'h44, 32'h00000000);
      chk("slverr", {31'h0, rd_err}, 32'h00000001);
      end_test("counting");
      rst();
      wr(`TCC_A_CTRLA, 32'h0000000f);
      wr(`TCC_A_PER, 32'h00000003);
      wr(`TCC_A_CTRLB, 32'h00000050);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_CAPT, 1'b0));
      wr(`TCC_A_CNT, 32'h00000012);
      ev(8'h1c, 8'h10, 8'h10);
      rdc("flags_cap", `TCC_A_FLAGS, 32'h00000050);
      rdc("cc_b_off", `TCC_A_CC0 + 8'h04, 32'h00000000);
      rdc("cc_c_rise", `TCC_A_CC0 + 8'h08, 32'h00008012);
      rdc("cc_a", `TCC_A_CC0, 32'h00000012);
      wr(`TCC_A_CNT, 32'h00000021);
      ev(8'h04, 8'h00, 8'h00);
      wr(`TCC_A_CNT, 32'h00000022);
      ev(8'h04, 8'h00, 8'h00);
      rdc("bv_a", `TCC_A_BVSTAT, 32'h00000002);
      wr(`TCC_A_CNT, 32'h00000023);
      ev(8'h14, 8'h10, 8'h00);
      rdc("flags_err", `TCC_A_FLAGS, 32'h00000052);
      rdc("cc_c_fall", `TCC_A_CC0 + 8'h08, 32'h00000023);
      rdc("queue_1", `TCC_A_CC0, 32'h00000021);
      rdc("queue_2", `TCC_A_CC0, 32'h00000022);
      rdc("queue_empty", `TCC_A_BVSTAT, 32'h00000000);
      wr(`TCC_A_CC0 + 8'h04, 32'h00001234);
      rdc("cc_b_wr", `TCC_A_CC0 + 8'h04, 32'h00001234);
      wr(`TCC_A_CCBUF0 + 8'h04, 32'h00005678);
      rdc("ccbuf_b_wr", `TCC_A_CCBUF0 + 8'h04, 32'h00005678);
      end_test("capture");
      rst();
      wr(`TCC_A_CTRLA, 32'h0000000f);
      wr(`TCC_A_CTRLB, 32'h00000010);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_FRQ, 1'b0));
      wr(`TCC_A_CNT, 32'h00000030);
      ev(8'h04, 8'h00, 8'h00);
      rdc("frq_restart", `TCC_A_CNT, 32'h00000000);
      rdc("frq_cap", `TCC_A_CC0, 32'h00000030);
      repeat (4) ev(8'h80, 8'h00, 8'h00);
      ev(8'h04, 8'h00, 8'h00);
      rdc("frq_cap2", `TCC_A_CC0, 32'h00000004);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_PW, 1'b0));
      wr(`TCC_A_CNT, 32'h00000040);
      ev(8'h04, 8'h04, 8'h04);
      rdc("pw_restart", `TCC_A_CNT, 32'h00000000);
      rdc("pw_no_cap", `TCC_A_FLAGS, 32'h00000000);
      repeat (5) ev(8'h80, 8'h00, 8'h00);
      ev(8'h04, 8'h04, 8'h00);
      rdc("pw_cap", `TCC_A_CC0, 32'h00000005);
      end_test("frequency_width");
      rst();
      wr(`TCC_A_CTRLA, 32'h0000000f);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_UPDN, 1'b0));
      wr(`TCC_A_CNT, 32'h00000005);
      ev(8'h84, 8'h00, 8'h00);
      rdc("updn_down", `TCC_A_CNT, 32'h00000004);
      ev(8'h80, 8'h00, 8'h00);
      rdc("updn_up", `TCC_A_CNT, 32'h00000005);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_QDEC, 1'b0));
      ev(8'h10, 8'h00, 8'h00);
      rdc("qdec_index", `TCC_A_CNT, 32'h00000000);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_RESTART, 1'b0));
      wr(`TCC_A_CNT, 32'h00000009);
      ev(8'h04, 8'h00, 8'h00);
      rdc("restart", `TCC_A_CNT, 32'h00000000);
      wr(`TCC_A_CTRLB, 32'h00000010);
      wr(`TCC_A_CTRLD, ea(tcc_pkg::TCC_EVA_CAPT, 1'b1));
      wr(`TCC_A_CNT, 32'h00000010);
      ev(8'h84, 8'h00, 8'h00);
      rdc("delay_cap", `TCC_A_CC0, 32'h00000011);
      end_test("event_actions");
      finish_test();
   end

   initial
   begin
      #400000;
      num_errors++;
      finish_test();
   end
endmodule // tcc_timer_test
